// ==== src/cfsp_consts.svh ====
// Purpose: Constants for the condition flags and stack pointer block
// Assumes: Included by the design modules
// Notes:   Field positions, reset values and frame sizes
`ifndef CFSP_CONSTS_SVH
`define CFSP_CONSTS_SVH
`define CFSP_BIT_CARRY      0
`define CFSP_BIT_ZERO       1
`define CFSP_BIT_NEG        2
`define CFSP_BIT_MASK       3
`define CFSP_BIT_HALF       4
`define CFSP_BIT_PRIO_UP    5
`define CFSP_FLAGS_RESET    8'he8
`define CFSP_SP_RESET       16'h01ff
`define CFSP_SP_FIXED       9'h003
`define CFSP_SP_LOW_BITS    7
`define CFSP_CALL_BYTES     3'h2
`define CFSP_IRQ_BYTES      3'h5
`define CFSP_PRIO_LVL0      2'h2
`define CFSP_PRIO_LVL1      2'h1
`define CFSP_PRIO_LVL2      2'h0
`define CFSP_PRIO_LVL3      2'h3
`endif

// ==== src/cfsp_pkg.sv ====
// Purpose: Types for the condition flags and stack pointer block
// Assumes: Constants come from cfsp_consts.svh
// Notes:   Operation codes issued by the execution datapath
package cfsp_pkg;
  typedef enum logic [3:0] {
    CFSP_OP_NONE   = 4'h0,
    CFSP_OP_ADD    = 4'h1,
    CFSP_OP_LOGIC  = 4'h2,
    CFSP_OP_SHIFT  = 4'h3,
    CFSP_OP_BTJ    = 4'h4,
    CFSP_OP_SETC   = 4'h5,
    CFSP_OP_CLRC   = 4'h6,
    CFSP_OP_MASK   = 4'h7,
    CFSP_OP_UNMASK = 4'h8,
    CFSP_OP_FLAGWR = 4'h9,
    CFSP_OP_WAIT   = 4'ha,
    CFSP_OP_ARITH  = 4'hb
  } cfsp_op_t;

  typedef struct packed {
    logic       valid;
    cfsp_op_t   op;
    logic [7:0] result;
    logic       carry;
    logic       half;
    logic [7:0] wdata;
  } cfsp_alu_t;

  typedef enum logic [2:0] {
    CFSP_ST_IDLE = 3'h0,
    CFSP_ST_PUSH = 3'h1,
    CFSP_ST_POP  = 3'h2
  } cfsp_state_t;

  typedef struct packed {
    logic       we;
    logic [15:0] addr;
    logic [7:0] data;
  } cfsp_mem_t;
endpackage

// ==== src/cfsp_stack_ptr.sv ====
// Purpose: Stack pointer with forced upper bits and silent wrap
// Assumes: At most one of push, pop, reload, write per cycle
// Notes:   Post-decrement push, pre-increment pop
`timescale 1ns/1ps
`include "cfsp_consts.svh"
module cfsp_stack_ptr
  import cfsp_pkg::*;
#(
  parameter int LOW_BITS = `CFSP_SP_LOW_BITS
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // Control
  input  wire logic        push,
  input  wire logic        pop,
  input  wire logic        reload,
  input  wire logic        low_we,
  input  wire logic [7:0]  low_wdata,
  // State
  output logic [15:0]      sp,
  output logic [15:0]      pop_addr
);
  // Pointer logic is written for a 7-bit low field only
  if (LOW_BITS != 7) begin : g_width_chk
    $error("cfsp_stack_ptr: only a 128-byte stack is served");
  end

  logic [6:0] low_ff;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      low_ff <= 7'h7f;
    end else if (reload) begin
      low_ff <= 7'h7f;
    end else if (low_we) begin
      low_ff <= low_wdata[6:0];
    end else if (push) begin
      low_ff <= low_ff - 7'h01;
    end else if (pop) begin
      low_ff <= low_ff + 7'h01;
    end
  end

  // Upper nine bits fixed; wrap falls out of the 7-bit width
  assign sp       = {`CFSP_SP_FIXED, low_ff};
  assign pop_addr = {`CFSP_SP_FIXED, 7'(low_ff + 7'h01)};
endmodule

// ==== src/cfsp_core.sv ====
// Purpose: Condition flags register and stack sequencing for the core
// Assumes: Datapath issues one op per cycle; memory write completes in one cycle
// Notes:   Flags push/pop and interrupt frames sequenced here
//
// Behaviour
// - Add and add-with-carry set half carry from bit 3 carry, else clear it.
// - Mask bit set on interrupt entry or by software; blocks all but trap.
// - Requests arriving while masked stay pending until the mask clears.
// - Mask set at service entry, restored by interrupt return.
// - Clearing mask in a routine services pending requests regardless of priority.
// - Negative flag copies bit 7 of every arithmetic, logic or data result.
// - Zero flag set when last result is zero, else cleared.
// - Carry from arithmetic; set/clear ops; bit-test, shift, rotate update it.
// - Interrupt entry loads bit 5 from the source priority registers; mask bit 3 is always set.
// - Priority bits also changed by mask ops, return, wait and flag pop.
// - Priority encoding: level0=10, level1=01, level2=00, level3=11.
// - Flags reset with bits 7,6,5,3 set; pushable and poppable.
// - Stack pointer points at next free byte; post-decrement push, pre-increment pop.
// - Upper nine pointer bits forced; reset or reload gives 01FFh.
// - Pointer wraps silently at either end of the stack.
// - Pointer low byte directly loadable and readable.
// - Interrupt pushes low PC first; call uses two bytes, interrupt five.
// - Second index register is never saved or restored by interrupts.
`timescale 1ns/1ps
`include "cfsp_consts.svh"
module cfsp_core
  import cfsp_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // Datapath results
  input  wire cfsp_alu_t   alu,
  // Interrupt sequencer
  input  wire logic        irq_req,
  input  wire logic        trap_req,
  input  wire logic [1:0]  src_prio,
  input  wire logic        irq_enter,
  input  wire logic        irq_return,
  input  wire logic        call,
  input  wire logic        ret,
  input  wire logic        flags_push,
  input  wire logic        flags_pop,
  input  wire logic        sp_reload,
  input  wire logic        sp_low_we,
  input  wire logic [7:0]  sp_low_wdata,
  // Context to save, and stack RAM read data
  input  wire logic [15:0] pc,
  input  wire logic [7:0]  index_x,
  input  wire logic [7:0]  accum,
  input  wire logic [7:0]  mem_rdata,
  // Outputs
  output logic [7:0]       condition_flags,
  output logic [15:0]      stack_pointer,
  output logic             irq_take,
  output logic             busy,
  output cfsp_mem_t        mem,
  output logic             ctx_valid,
  output logic [2:0]       ctx_sel,
  output logic [7:0]       ctx_data
);
  logic [7:0]  flags_ff;
  logic [7:0]  nxt_flags;
  logic        pend_ff;
  logic        take_ff;
  cfsp_state_t state_ff;
  logic [2:0]  cnt_ff;
  logic [2:0]  len_ff;
  logic        irq_frame_ff;
  logic        busy_ff;
  cfsp_mem_t   mem_ff;
  logic        ctx_valid_ff;
  logic [2:0]  ctx_sel_ff;
  logic [7:0]  ctx_data_ff;
  logic [15:0] sp;
  logic [15:0] pop_addr;
  logic        sp_push;
  logic        sp_pop;
  logic        pop_ph_ff;
  logic [7:0]  push_byte;
  logic [7:0]  frame_flags_ff;

  // Interrupt frame order: PROGRAM_COUNTER_LOW, PCH, X, A, flags; no Y slot exists
  always_comb begin
    case (cnt_ff)
      3'h0:    push_byte = pc[7:0];
      3'h1:    push_byte = pc[15:8];
      3'h2:    push_byte = index_x;
      3'h3:    push_byte = accum;
      // Entry rewrites mask and priority first; frame keeps the old copy
      default: push_byte = irq_frame_ff ? frame_flags_ff : flags_ff;
    endcase
  end

  cfsp_stack_ptr #(
    .LOW_BITS (`CFSP_SP_LOW_BITS)
  ) u_sp (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .push      (sp_push),
    .pop       (sp_pop),
    .reload    (sp_reload),
    .low_we    (sp_low_we),
    .low_wdata (sp_low_wdata),
    .sp        (sp),
    .pop_addr  (pop_addr)
  );

  assign sp_push = (state_ff == CFSP_ST_PUSH);
  assign sp_pop  = (state_ff == CFSP_ST_POP) && !pop_ph_ff;

  // Frame sequencer
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_ff     <= CFSP_ST_IDLE;
      cnt_ff       <= 3'h0;
      len_ff       <= 3'h0;
      irq_frame_ff <= 1'b0;
      pop_ph_ff    <= 1'b0;
      frame_flags_ff <= 8'h00;
    end else begin
      case (state_ff)
        CFSP_ST_IDLE: begin
          cnt_ff    <= 3'h0;
          pop_ph_ff <= 1'b0;
          if (irq_enter) begin
            state_ff     <= CFSP_ST_PUSH;
            len_ff       <= `CFSP_IRQ_BYTES;
            irq_frame_ff <= 1'b1;
            frame_flags_ff <= flags_ff;
          end else if (call) begin
            state_ff     <= CFSP_ST_PUSH;
            len_ff       <= `CFSP_CALL_BYTES;
            irq_frame_ff <= 1'b0;
          end else if (flags_push) begin
            state_ff     <= CFSP_ST_PUSH;
            len_ff       <= 3'h1;
            cnt_ff       <= 3'h4;
            irq_frame_ff <= 1'b0;
          end else if (irq_return) begin
            state_ff     <= CFSP_ST_POP;
            len_ff       <= `CFSP_IRQ_BYTES;
            irq_frame_ff <= 1'b1;
          end else if (ret) begin
            state_ff     <= CFSP_ST_POP;
            len_ff       <= `CFSP_CALL_BYTES;
            cnt_ff       <= 3'h3;
            irq_frame_ff <= 1'b0;
          end else if (flags_pop) begin
            state_ff     <= CFSP_ST_POP;
            len_ff       <= 3'h1;
            irq_frame_ff <= 1'b0;
          end
        end
        CFSP_ST_PUSH: begin
          cnt_ff <= cnt_ff + 3'h1;
          len_ff <= len_ff - 3'h1;
          if (len_ff == 3'h1) begin
            state_ff <= CFSP_ST_IDLE;
          end
        end
        CFSP_ST_POP: begin
          // Two phases: address, then capture the read byte
          pop_ph_ff <= !pop_ph_ff;
          if (pop_ph_ff) begin
            cnt_ff <= cnt_ff + 3'h1;
            len_ff <= len_ff - 3'h1;
            if (len_ff == 3'h1) begin
              state_ff <= CFSP_ST_IDLE;
            end
          end
        end
        default: state_ff <= CFSP_ST_IDLE;
      endcase
    end
  end

  // Memory port and popped context
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mem_ff       <= '0;
      ctx_valid_ff <= 1'b0;
      ctx_sel_ff   <= 3'h0;
      ctx_data_ff  <= 8'h00;
    end else begin
      mem_ff.we    <= sp_push;
      mem_ff.addr  <= sp_push ? sp : pop_addr;
      mem_ff.data  <= push_byte;
      ctx_valid_ff <= 1'b0;
      if ((state_ff == CFSP_ST_POP) && pop_ph_ff) begin
        // Reverse order: flags, A, X, PCH, PROGRAM_COUNTER_LOW
        ctx_valid_ff <= 1'b1;
        ctx_sel_ff   <= cnt_ff;
        ctx_data_ff  <= mem_rdata;
      end
    end
  end

  // Pending request latch; a new request beats the service clear
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pend_ff <= 1'b0;
    end else if (irq_req) begin
      pend_ff <= 1'b1;
    end else if (irq_enter) begin
      pend_ff <= 1'b0;
    end
  end

  // Service allowed for trap, or pending with mask clear; priority ignored
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      take_ff <= 1'b0;
    end else begin
      take_ff <= trap_req ||
                 ((pend_ff || irq_req) && !flags_ff[`CFSP_BIT_MASK]);
    end
  end

  // Flags next value
  always_comb begin
    nxt_flags = flags_ff;
    if (irq_enter) begin
      nxt_flags[`CFSP_BIT_PRIO_UP] = src_prio[1];
      nxt_flags[`CFSP_BIT_MASK]    = src_prio[0];
      if (src_prio == `CFSP_PRIO_LVL0 || src_prio == `CFSP_PRIO_LVL2) begin
        nxt_flags[`CFSP_BIT_MASK] = 1'b1;
      end
    end else if (alu.valid) begin
      case (alu.op)
        CFSP_OP_ADD: begin
          nxt_flags[`CFSP_BIT_HALF]  = alu.half;
          nxt_flags[`CFSP_BIT_NEG]   = alu.result[7];
          nxt_flags[`CFSP_BIT_ZERO]  = (alu.result == 8'h00);
          nxt_flags[`CFSP_BIT_CARRY] = alu.carry;
        end
        CFSP_OP_ARITH, CFSP_OP_SHIFT: begin
          nxt_flags[`CFSP_BIT_NEG]   = alu.result[7];
          nxt_flags[`CFSP_BIT_ZERO]  = (alu.result == 8'h00);
          nxt_flags[`CFSP_BIT_CARRY] = alu.carry;
        end
        CFSP_OP_LOGIC: begin
          nxt_flags[`CFSP_BIT_NEG]  = alu.result[7];
          nxt_flags[`CFSP_BIT_ZERO] = (alu.result == 8'h00);
        end
        CFSP_OP_BTJ:  nxt_flags[`CFSP_BIT_CARRY] = alu.carry;
        CFSP_OP_SETC: nxt_flags[`CFSP_BIT_CARRY] = 1'b1;
        CFSP_OP_CLRC: nxt_flags[`CFSP_BIT_CARRY] = 1'b0;
        CFSP_OP_MASK: begin
          nxt_flags[`CFSP_BIT_PRIO_UP] = 1'b1;
          nxt_flags[`CFSP_BIT_MASK]    = 1'b1;
        end
        CFSP_OP_UNMASK, CFSP_OP_WAIT: begin
          nxt_flags[`CFSP_BIT_PRIO_UP] = 1'b1;
          nxt_flags[`CFSP_BIT_MASK]    = 1'b0;
        end
        CFSP_OP_FLAGWR: nxt_flags = alu.wdata | 8'hc0;
        default: nxt_flags = flags_ff;
      endcase
    end
    // Popped flags byte restores mask and priority on return
    if ((state_ff == CFSP_ST_POP) && pop_ph_ff && (cnt_ff == 3'h0) && (len_ff != `CFSP_CALL_BYTES)) begin
      nxt_flags = mem_rdata | 8'hc0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      flags_ff <= `CFSP_FLAGS_RESET;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= (state_ff != CFSP_ST_IDLE) || irq_enter || call || ret ||
                 irq_return || flags_push || flags_pop;
    end
  end

  logic [15:0] sp_out_ff;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sp_out_ff <= `CFSP_SP_RESET;
    end else begin
      sp_out_ff <= sp;
    end
  end

  assign condition_flags = flags_ff;
  assign stack_pointer   = sp_out_ff;
  assign irq_take        = take_ff;
  assign busy            = busy_ff;
  assign mem             = mem_ff;
  assign ctx_valid       = ctx_valid_ff;
  assign ctx_sel         = ctx_sel_ff;
  assign ctx_data        = ctx_data_ff;
endmodule

// ==== bench/cfsp_stack_mem.sv ====
// Purpose: Stack RAM partner behind the core's memory port
// Assumes: Reads combinational, writes on the rising edge
// Notes:   Only address bits 6:0 decode, so both stack ends alias cleanly
`timescale 1ns/1ps
module cfsp_stack_mem
  import cfsp_pkg::*;
(
  // Clock
  input  wire logic      ref_clk,
  // Core side
  input  wire cfsp_mem_t mem,
  output logic [7:0]     mem_rdata
);
  logic [7:0] ram [128];
  always_ff @(posedge ref_clk) begin
    if (mem.we) begin
      ram[mem.addr[6:0]] <= mem.data;
    end
  end
  assign mem_rdata = ram[mem.addr[6:0]];
endmodule

// ==== bench/cfsp_core_chk.sv ====
// Purpose: Port assertions for cfsp_core
// Assumes: One clock, async active-high reset
// Notes:   Delays allow for the pointer output lagging a cycle
`timescale 1ns/1ps
module cfsp_core_chk
  import cfsp_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        reset,
  // Requests
  input wire cfsp_alu_t   alu,
  input wire logic        trap_req,
  input wire logic        irq_enter,
  input wire logic        sp_reload,
  input wire logic [15:0] pc,
  // Responses
  input wire logic [7:0]  condition_flags,
  input wire logic [15:0] stack_pointer,
  input wire logic        irq_take,
  input wire logic        busy,
  input wire cfsp_mem_t   mem
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic go;
  logic nz;
  logic ent;
  assign go = alu.valid && !busy && !irq_enter;
  assign nz = alu.op inside {CFSP_OP_ADD, CFSP_OP_ARITH, CFSP_OP_LOGIC, CFSP_OP_SHIFT};
  assign ent = irq_enter && !busy;
  AST_SP_UPPER: assert property (stack_pointer[15:7] == 9'h003)
    else $error("pointer upper bits moved");
  AST_FLAGS_TOP: assert property (condition_flags[7:6] == 2'h3)
    else $error("flag bits 7:6 not one");
  AST_HALF: assert property (go && alu.op == CFSP_OP_ADD |-> ##1 condition_flags[4] == $past(alu.half))
    else $error("half carry wrong");
  AST_NEG_ZERO: assert property (go && nz |-> ##1
    condition_flags[2:1] == {$past(alu.result[7]), $past(alu.result) == 8'h00})
    else $error("negative or zero wrong");
  AST_SETC: assert property (go && alu.op == CFSP_OP_SETC |-> ##1 condition_flags[0])
    else $error("carry not set");
  AST_CLRC: assert property (go && alu.op == CFSP_OP_CLRC |-> ##1 !condition_flags[0])
    else $error("carry not cleared");
  AST_MASK_LVL: assert property (go && alu.op == CFSP_OP_MASK |-> ##1 condition_flags[5] && condition_flags[3])
    else $error("mask level wrong");
  AST_UNMASK_LVL: assert property (go && alu.op == CFSP_OP_UNMASK |-> ##1 condition_flags[5] && !condition_flags[3])
    else $error("unmask level wrong");
  AST_FRAME_WR: assert property (ent |-> ##2 mem.we [*5] ##1 !mem.we)
    else $error("frame write count wrong");
  AST_FRAME_FIRST: assert property (ent |-> ##2 mem.addr == $past(stack_pointer) && mem.data == $past(pc[7:0]))
    else $error("first frame byte wrong");
  AST_FRAME_SP: assert property (ent |-> ##8 stack_pointer[6:0] == $past(stack_pointer[6:0], 7) - 7'h05)
    else $error("pointer not down by five");
  AST_ENTRY_MASK: assert property (ent |-> ##8 condition_flags[3])
    else $error("mask not set on entry");
  AST_RELOAD: assert property (sp_reload |-> ##2 stack_pointer == 16'h01ff)
    else $error("reload value wrong");
  AST_TRAP: assert property (trap_req |-> ##[1:3] irq_take)
    else $error("trap not taken");
  cover property (ent);
  cover property (trap_req ##[1:3] irq_take);
  cover property (go && alu.op == CFSP_OP_MASK);
endmodule
bind cfsp_core cfsp_core_chk chk_u (
  .ref_clk, .reset, .alu, .trap_req, .irq_enter, .sp_reload, .pc,
  .condition_flags, .stack_pointer, .irq_take, .busy, .mem
);

// ==== bench/cfsp_core_tb.sv ====
// Purpose: Self-checking bench for cfsp_core
// Assumes: Stack RAM model answers reads combinationally
// Notes:   Inputs move on the falling edge only, away from sampling
`timescale 1ns/1ps
module cfsp_core_tb
  import cfsp_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  cfsp_alu_t   alu;
  logic        irq_req, trap_req, irq_enter, irq_return, call, ret, sp_reload, sp_low_we;
  logic        flags_push, flags_pop;
  logic [1:0]  src_prio;
  logic [7:0]  sp_low_wdata, index_x, accum, mem_rdata, condition_flags, ctx_data;
  logic [15:0] pc, stack_pointer;
  logic        irq_take, busy, ctx_valid;
  logic [2:0]  ctx_sel;
  cfsp_mem_t   mem;
  logic [10:0] ctx_q [$];
  int          error_cnt = 0;
  int          checks = 0;
  int          n;
  always #25 ref_clk = ~ref_clk;
  cfsp_core dut_u (.ref_clk, .reset, .alu, .irq_req, .trap_req, .src_prio, .irq_enter, .irq_return, .call, .ret,
    .flags_push, .flags_pop, .sp_reload, .sp_low_we, .sp_low_wdata, .pc, .index_x, .accum,
    .mem_rdata, .condition_flags, .stack_pointer, .irq_take, .busy, .mem, .ctx_valid, .ctx_sel, .ctx_data);
  cfsp_stack_mem mem_u (.ref_clk, .mem, .mem_rdata);
  always @(posedge ref_clk) begin
    if (ctx_valid === 1'b1) ctx_q.push_back({ctx_sel, ctx_data});
  end
  task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic aluc(cfsp_op_t o, logic [7:0] r, logic c, logic h, logic [7:0] e);
    @(negedge ref_clk) alu = '{1'b1, o, r, c, h, r};
    @(negedge ref_clk) alu.valid = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk("condition_flags", {8'h0, e}, {8'h0, condition_flags});
  endtask
  // Extra idle cycles cover the pointer output lag
  task automatic frame(ref logic s);
    @(negedge ref_clk) s = 1'b1;
    @(negedge ref_clk) s = 1'b0;
    @(negedge ref_clk);
    n = 0;
    while (busy !== 1'b0 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic t_alu;
    chk("reset_flags", 16'hf, {12'h0, condition_flags[7:5], condition_flags[3]});
    chk("reset_sp", 16'h01ff, stack_pointer);
    aluc(CFSP_OP_ADD, 8'h00, 1'b1, 1'b1, 8'hfb);
    aluc(CFSP_OP_ADD, 8'h7f, 1'b0, 1'b0, 8'he8);
    aluc(CFSP_OP_ARITH, 8'h80, 1'b1, 1'b0, 8'hed);
    aluc(CFSP_OP_LOGIC, 8'h00, 1'b0, 1'b0, 8'heb);
    aluc(CFSP_OP_SHIFT, 8'h81, 1'b0, 1'b0, 8'hec);
    aluc(CFSP_OP_BTJ, 8'h80, 1'b1, 1'b0, 8'hed);
    aluc(CFSP_OP_CLRC, 8'h00, 1'b0, 1'b0, 8'hec);
    aluc(CFSP_OP_SETC, 8'h00, 1'b0, 1'b0, 8'hed);
    aluc(CFSP_OP_UNMASK, 8'h00, 1'b0, 1'b0, 8'he5);
    aluc(CFSP_OP_MASK, 8'h00, 1'b0, 1'b0, 8'hed);
    aluc(CFSP_OP_WAIT, 8'h00, 1'b0, 1'b0, 8'he5);
    aluc(CFSP_OP_FLAGWR, 8'h16, 1'b0, 1'b0, 8'hd6);
    aluc(CFSP_OP_MASK, 8'h00, 1'b0, 1'b0, 8'hfe);
    $display("alu done");
  endtask
  task automatic t_pending;
    logic seen;
    @(negedge ref_clk) irq_req = 1'b1;
    @(negedge ref_clk) irq_req = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk("take_masked", 16'h0, {15'h0, irq_take});
    @(negedge ref_clk) trap_req = 1'b1;
    @(negedge ref_clk) trap_req = 1'b0;
    seen = irq_take;
    repeat (2) @(negedge ref_clk) seen |= irq_take;
    chk("take_trap", 16'h1, {15'h0, seen});
    aluc(CFSP_OP_UNMASK, 8'h00, 1'b0, 1'b0, 8'hf6);
    chk("take_pending", 16'h1, {15'h0, irq_take});
    $display("pending done");
  endtask
  task automatic t_frame;
    logic [7:0] ex [5];
    ex = '{8'h34, 8'h12, 8'h56, 8'h78, 8'hf5};
    aluc(CFSP_OP_ADD, 8'h80, 1'b1, 1'b1, 8'hf5);
    frame(irq_enter);
    chk("entry_flags", 16'h00dd, {8'h0, condition_flags});
    chk("entry_sp", 16'h01fa, stack_pointer);
    for (int i = 0; i < 5; i++) chk("frame_byte", {8'h0, ex[i]}, {8'h0, mem_u.ram[127 - i]});
    ctx_q.delete();
    frame(irq_return);
    chk("ctx_count", 16'h5, 16'(ctx_q.size()));
    for (int i = 0; i < 5; i++) chk("ctx", {5'h0, i[2:0], ex[4 - i]}, {5'h0, ctx_q[i]});
    chk("return_flags", 16'h00f5, {8'h0, condition_flags});
    chk("return_sp", 16'h01ff, stack_pointer);
    $display("frame done");
  endtask
  task automatic t_wrap;
    frame(sp_low_we);
    chk("low_write", 16'h0180, stack_pointer);
    frame(call);
    chk("call_sp", 16'h01fe, stack_pointer);
    chk("wrap_bytes", 16'h1234, {mem_u.ram[127], mem_u.ram[0]});
    ctx_q.delete();
    frame(ret);
    chk("ret_sp", 16'h0180, stack_pointer);
    chk("ret_count", 16'h2, 16'(ctx_q.size()));
    chk("ret_pch", 16'h0312, {5'h0, ctx_q[0]});
    chk("ret_pcl", 16'h0434, {5'h0, ctx_q[1]});
    frame(sp_reload);
    chk("reload_sp", 16'h01ff, stack_pointer);
    frame(flags_push);
    chk("fpush_sp", 16'h01fe, stack_pointer);
    chk("fpush_byte", 16'h00f5, {8'h0, mem_u.ram[127]});
    aluc(CFSP_OP_FLAGWR, 8'h00, 1'b0, 1'b0, 8'hc0);
    ctx_q.delete();
    frame(flags_pop);
    chk("fpop_flags", 16'h00f5, {8'h0, condition_flags});
    chk("fpop_sp", 16'h01ff, stack_pointer);
    chk("fpop_ctx", 16'h00f5, {5'h0, ctx_q[0]});
    $display("wrap done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    {irq_req, trap_req, irq_enter, irq_return, call, ret, sp_reload, sp_low_we} = '0;
    {flags_push, flags_pop} = '0;
    alu = '0;
    src_prio = 2'h1;
    sp_low_wdata = 8'h00;
    pc = 16'h1234;
    index_x = 8'h56;
    accum = 8'h78;
    repeat (2) @(negedge ref_clk);
    reset = 1'b0;
    t_alu();
    t_pending();
    t_frame();
    t_wrap();
    wrap_up();
  end
  // Run needs about 8 us; generous margin before calling it a hang
  initial begin
    #100us;
    error_cnt++;
    wrap_up();
  end
endmodule
